// [verilog/tdl_regs.vh]
// Purpose: constants shared by the tap delay line control files
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef TDL_REGS_VH
`define TDL_REGS_VH

// ****************************************************************
// tap geometry
// ****************************************************************
`define TDL_TAP_BITS      6
`define TDL_TAP_COUNT     64
`define TDL_TAP_MAX       6'h3F
`define TDL_TAP_ZERO      6'h00
`define TDL_TAP_ONE       6'h01

// ****************************************************************
// delay_mode_select encodings
// ****************************************************************
`define TDL_MODE_BITS     2
`define TDL_MODE_ZERO_HOLD 2'h0
`define TDL_MODE_FIXED    2'h1
`define TDL_MODE_VARIABLE 2'h2

// ****************************************************************
// apb register byte addresses
// ****************************************************************
`define TDL_ADDR_BITS     12
`define TDL_ADDR_CMD      12'h000
`define TDL_ADDR_STATUS   12'h004
`define TDL_ADDR_STEPCNT  12'h008
`define TDL_ADDR_INIT     12'h00C

// ****************************************************************
// field positions
// ****************************************************************
`define TDL_CMD_STEP      0
`define TDL_CMD_DIR       1
`define TDL_CMD_RESET     2
`define TDL_STAT_TAP_LSB  0
`define TDL_STAT_TAP_MSB  5
`define TDL_STAT_MODE_LSB 8
`define TDL_STAT_MODE_MSB 9
`define TDL_STAT_VAR      16
`define TDL_STAT_AT_INIT  17

// ****************************************************************
// reset values and widths
// ****************************************************************
`define TDL_DATA_BITS     32
`define TDL_CNT_BITS      16
`define TDL_WORD_ZERO     32'h00000000
`define TDL_CNT_ZERO      16'h0000
`define TDL_CNT_ONE       16'h0001
`define TDL_CNT_MAX       16'hFFFF

`endif

// [verilog/tdl_tap_chain.v]
// Purpose: 64-tap delay chain with a tap selector
// Assumes: each stage stands for one calibrated tap element
// Notes:   purely combinational from pad to output
`timescale 1ns/1ns
`include "tdl_regs.vh"

module tdl_tap_chain #(
  parameter TAPS     = `TDL_TAP_COUNT,
  parameter SEL_BITS = `TDL_TAP_BITS
) (
  input  wire                pad_in,
  input  wire [SEL_BITS-1:0] tap_sel,
  output wire                delayed_out
);

  // ****************************************************************
  // delay stages
  // ****************************************************************
  // in rtl each stage is a plain wire; the real element adds one
  // tap_step_resolution of delay per stage
  wire [TAPS-1:0] stage;

  assign stage[0] = pad_in;

  genvar i;
  generate
    for (i = 1; i < TAPS; i = i + 1) begin : g_stage
      assign stage[i] = stage[i-1];
    end
  endgenerate

  // ****************************************************************
  // tap selection
  // ****************************************************************
  // selection is a mux, not a register, so the pad path stays
  // combinational and may feed fabric or capture flops alike
  assign delayed_out = stage[tap_sel];

endmodule // tdl_tap_chain

// [verilog/tdl_delay_line.v]
// Purpose: control of a per-input programmable tap delay line
// Assumes: step controls come from logic on pclk, no synchroniser
// Notes:   mode and initial tap are configuration parameters;
//          apb gives software status and a step command port
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "tdl_regs.vh"

module tdl_delay_line #(
  parameter [`TDL_MODE_BITS-1:0] DELAY_MODE_SELECT = `TDL_MODE_ZERO_HOLD,
  parameter [`TDL_TAP_BITS-1:0]  INITIAL_TAP_VALUE = `TDL_TAP_ZERO
) (
  input  wire                      pclk,
  input  wire                      presetn,
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [`TDL_ADDR_BITS-1:0] paddr,
  input  wire [`TDL_DATA_BITS-1:0] pwdata,
  output reg  [`TDL_DATA_BITS-1:0] prdata,
  output reg                       pready,
  output reg                       pslverr,
  input  wire                      pad_in,
  output wire                      delayed_out,
  input  wire                      step_enable,
  input  wire                      step_direction,
  input  wire                      tap_reset,
  output reg  [`TDL_TAP_BITS-1:0]  tap_position
);

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // the mode is fixed at build time, so these fold to constants
  wire mode_variable;
  wire mode_fixed;
  wire mode_zero_hold;

  assign mode_variable  = (DELAY_MODE_SELECT == `TDL_MODE_VARIABLE);
  assign mode_fixed     = (DELAY_MODE_SELECT == `TDL_MODE_FIXED);
  assign mode_zero_hold = ~mode_variable & ~mode_fixed;

  // ****************************************************************
  // apb access phase decode
  // ****************************************************************
  wire setup_phase;
  wire access_done;
  wire wr_done;
  reg  hit_cmd;
  reg  hit_status;
  reg  hit_stepcnt;
  reg  hit_init;
  reg  hit_any;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done     = access_done & pwrite & ~pslverr;

  // at most one hit; an unmapped address leaves hit_any low
  always @* begin
    hit_cmd     = 1'b0;
    hit_status  = 1'b0;
    hit_stepcnt = 1'b0;
    hit_init    = 1'b0;
    hit_any     = 1'b1;
    if (paddr == `TDL_ADDR_CMD) begin
      hit_cmd = 1'b1;
    end else if (paddr == `TDL_ADDR_STATUS) begin
      hit_status = 1'b1;
    end else if (paddr == `TDL_ADDR_STEPCNT) begin
      hit_stepcnt = 1'b1;
    end else if (paddr == `TDL_ADDR_INIT) begin
      hit_init = 1'b1;
    end else begin
      hit_any = 1'b0;
    end
  end

  // ****************************************************************
  // software step command
  // ****************************************************************
  // a write to the command word gives a one-cycle request that acts
  // on the edge after the write completes, like a pin request
  reg  sw_step;
  reg  sw_dir;
  reg  sw_reset;
  wire next_sw_step;
  wire next_sw_dir;
  wire next_sw_reset;

  assign next_sw_step  = wr_done & hit_cmd & pwdata[`TDL_CMD_STEP];
  assign next_sw_dir   = wr_done & hit_cmd & pwdata[`TDL_CMD_DIR];
  assign next_sw_reset = wr_done & hit_cmd & pwdata[`TDL_CMD_RESET];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_step  <= 1'b0;
      sw_dir   <= 1'b0;
      sw_reset <= 1'b0;
    end else begin
      sw_step  <= next_sw_step;
      sw_dir   <= next_sw_dir;
      sw_reset <= next_sw_reset;
    end
  end

  // ****************************************************************
  // request arbitration
  // ****************************************************************
  // a reset from pin or software beats any step, and a pin step wins over a software step; a software step that meets a pin step
  // on the same edge is dropped rather than queued
  wire any_reset;
  wire any_step;
  wire any_dir;
  wire do_reset;
  wire do_step;

  assign any_reset = tap_reset | sw_reset;
  assign any_step  = step_enable | sw_step;
  assign any_dir   = step_enable ? step_direction : sw_dir;
  assign do_reset  = mode_variable & any_reset;
  assign do_step   = mode_variable & ~any_reset & any_step;

  // ****************************************************************
  // tap arithmetic
  // ****************************************************************
  reg [`TDL_TAP_BITS-1:0] tap_up;
  reg [`TDL_TAP_BITS-1:0] tap_down;

  always @* begin
    if (tap_position == `TDL_TAP_MAX) begin
      tap_up = `TDL_TAP_ZERO;
    end else begin
      tap_up = tap_position + `TDL_TAP_ONE;
    end
    if (tap_position == `TDL_TAP_ZERO) begin
      tap_down = `TDL_TAP_MAX;
    end else begin
      tap_down = tap_position - `TDL_TAP_ONE;
    end
  end

  // ****************************************************************
  // next tap position
  // ****************************************************************
  reg [`TDL_TAP_BITS-1:0] next_tap_position;

  always @* begin
    next_tap_position = tap_position;
    if (do_reset) begin
      next_tap_position = INITIAL_TAP_VALUE;
    end else if (do_step) begin
      if (any_dir) begin
        next_tap_position = tap_up;
      end else begin
        next_tap_position = tap_down;
      end
    end
  end

  // ****************************************************************
  // tap register
  // ****************************************************************
  // release of presetn stands for the end of configuration; in fixed
  // and zero-hold modes nothing but that load ever writes the tap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_position <= INITIAL_TAP_VALUE;
    end else begin
      tap_position <= next_tap_position;
    end
  end

  // ****************************************************************
  // delay chain
  // ****************************************************************
  // left combinational on purpose: a flop here would add a cycle of
  // latency to the pad path and defeat the zero-hold use
  tdl_tap_chain #(
    .TAPS     (`TDL_TAP_COUNT),
    .SEL_BITS (`TDL_TAP_BITS)
  ) u_chain (
    .pad_in      (pad_in),
    .tap_sel     (tap_position),
    .delayed_out (delayed_out)
  );

  // ****************************************************************
  // step counter
  // ****************************************************************
  // saturates instead of wrapping so software never misreads a
  // busy line as idle; a write of any value clears it, and a step on
  // the clearing edge is still counted
  reg  [`TDL_CNT_BITS-1:0] step_count;
  reg  [`TDL_CNT_BITS-1:0] next_step_count;
  wire                     cnt_clear;

  assign cnt_clear = wr_done & hit_stepcnt;

  always @* begin
    next_step_count = step_count;
    if (cnt_clear) begin
      next_step_count = `TDL_CNT_ZERO;
    end
    if (do_step) begin
      if (cnt_clear) begin
        next_step_count = `TDL_CNT_ONE;
      end else if (step_count != `TDL_CNT_MAX) begin
        next_step_count = step_count + `TDL_CNT_ONE;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_count <= `TDL_CNT_ZERO;
    end else begin
      step_count <= next_step_count;
    end
  end

  // ****************************************************************
  // read data mux
  // ****************************************************************
  reg [`TDL_DATA_BITS-1:0] read_word;

  always @* begin
    read_word = `TDL_WORD_ZERO;
    if (hit_status) begin
      read_word[`TDL_STAT_TAP_MSB:`TDL_STAT_TAP_LSB]   = tap_position;
      read_word[`TDL_STAT_MODE_MSB:`TDL_STAT_MODE_LSB] = DELAY_MODE_SELECT;
      read_word[`TDL_STAT_VAR]                         = mode_variable;
      read_word[`TDL_STAT_AT_INIT] = (tap_position == INITIAL_TAP_VALUE);
    end else if (hit_stepcnt) begin
      read_word[`TDL_CNT_BITS-1:0] = step_count;
    end else if (hit_init) begin
      read_word[`TDL_TAP_BITS-1:0] = INITIAL_TAP_VALUE;
    end else begin
      read_word = `TDL_WORD_ZERO;
    end
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  // answer is built in the setup cycle, so every access completes at
  // its first access edge; status read reflects the tap as it stood
  // at the setup edge
  reg                      next_pready;
  reg                      next_pslverr;
  reg [`TDL_DATA_BITS-1:0] next_prdata;

  always @* begin
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = `TDL_WORD_ZERO;
    if (setup_phase) begin
      next_pready  = 1'b1;
      if (!hit_any) begin
        next_pslverr = 1'b1;
      end else if (pwrite & (hit_status | hit_init)) begin
        next_pslverr = 1'b1; // read-only words refuse writes
      end
      if (!pwrite) begin
        next_prdata = read_word;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `TDL_WORD_ZERO;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // mode_zero_hold only documents the third case; it steers nothing
  // beyond what mode_variable already excludes
  wire unused_mode;
  assign unused_mode = mode_zero_hold;

endmodule // tdl_delay_line

// [bench/tdl_monitor.sv]
// Purpose: port checker for tdl_delay_line
// Assumes: one pclk domain, presetn async low
// Notes:   bound after the module
`timescale 1ns/1ns
`include "tdl_regs.vh"
module tdl_monitor #(
  parameter [1:0] DELAY_MODE_SELECT = 2'h0,
  parameter [5:0] INITIAL_TAP_VALUE = 6'h00
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pad_in,
  input wire        delayed_out,
  input wire        step_enable,
  input wire        step_direction,
  input wire        tap_reset,
  input wire [5:0]  tap_position
);
  // ****************
  // properties
  // ****************
  wire var_m = DELAY_MODE_SELECT == `TDL_MODE_VARIABLE;
  reg  sw_req;
  reg  sw_rst;
  // software commands act one edge late, so hold checks skip them;
  // a software reset also beats a pin step on the edge it acts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_req <= 1'b0;
      sw_rst <= 1'b0;
    end else begin
      sw_req <= psel & penable & pready & pwrite & (paddr == `TDL_ADDR_CMD) & (|pwdata[2:0]);
      sw_rst <= psel & penable & pready & pwrite & (paddr == `TDL_ADDR_CMD) & pwdata[`TDL_CMD_RESET];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_load; var_m && tap_reset |=> tap_position == INITIAL_TAP_VALUE; endproperty
  a_load: assert property (p_load) else $error("tap not reloaded");
  property p_inc; var_m && !tap_reset && !sw_rst && step_enable && step_direction |=>
    tap_position == $past(tap_position) + 6'h01; endproperty
  a_inc: assert property (p_inc) else $error("bad increment");
  property p_dec; var_m && !tap_reset && !sw_rst && step_enable && !step_direction |=>
    tap_position == $past(tap_position) - 6'h01; endproperty
  a_dec: assert property (p_dec) else $error("bad decrement");
  property p_hold; !tap_reset && !step_enable && !sw_req |=> $stable(tap_position); endproperty
  a_hold: assert property (p_hold) else $error("tap moved while idle");
  property p_cause; !$stable(tap_position) |-> $past(tap_reset || step_enable || sw_req); endproperty
  a_cause: assert property (p_cause) else $error("tap moved without request");
  property p_comb; delayed_out == pad_in; endproperty
  a_comb: assert property (p_comb) else $error("output not following pad");
  property p_two; var_m && step_enable && !tap_reset && !sw_rst ##1 step_enable && !tap_reset && !sw_rst &&
    step_direction == $past(step_direction) |=>
    tap_position == $past(tap_position, 2) + ($past(step_direction) ? 6'h02 : 6'h3E); endproperty
  a_two: assert property (p_two) else $error("run of steps wrong");
  property p_stay; var_m && tap_reset ##1 !tap_reset && !step_enable && !sw_req |=>
    tap_position == INITIAL_TAP_VALUE; endproperty
  a_stay: assert property (p_stay) else $error("initial tap not kept");
endmodule // tdl_monitor
bind tdl_delay_line tdl_monitor #(.DELAY_MODE_SELECT(DELAY_MODE_SELECT), .INITIAL_TAP_VALUE(INITIAL_TAP_VALUE))
  u_tdl_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pad_in(pad_in), .delayed_out(delayed_out),
  .step_enable(step_enable), .step_direction(step_direction), .tap_reset(tap_reset),
  .tap_position(tap_position));

// [bench/tdl_step_driver.sv]
// Purpose: user logic driving the tap step pins
// Assumes: pclk runs all the time
// Notes:   random bursts when active, else held levels
`timescale 1ns/1ns
module tdl_step_driver (
  input  wire pclk,
  input  wire presetn,
  input  wire active,
  input  wire slow,
  input  wire hold_en,
  input  wire hold_dir,
  input  wire hold_rst,
  output reg  step_enable,
  output reg  step_direction,
  output reg  tap_reset
);
  integer    seed;
  reg [31:0] r;
  initial seed = 32'h18EB;
  // pins change only just after pclk edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_enable    <= 1'b0;
      step_direction <= 1'b0;
      tap_reset      <= 1'b0;
      r              <= 32'h0000_0000;
    end else if (active) begin
      r <= $random(seed);
      // slow mode keeps the enable level for longer runs
      if (!slow || r[7:6] == 2'b00)
        step_enable <= r[0];
      step_direction <= r[1];
      tap_reset      <= r[5:2] == 4'h0;
    end else begin
      step_enable    <= hold_en;
      step_direction <= hold_dir;
      tap_reset      <= hold_rst;
    end
  end
endmodule // tdl_step_driver

// [bench/testbench.sv]
// Purpose: self-checking bench for tdl_delay_line
// Assumes: main copy variable mode, initial tap 5; two static copies
// Notes:   a tap reference model runs beside the design
`timescale 1ns/1ns
`include "tdl_regs.vh"
module testbench;
  localparam [5:0] INIT = 6'h05;
  reg         pclk, presetn, psel, penable, pwrite, pad_in, err;
  reg         active, slow, hold_en, hold_dir, hold_rst, sw_v;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [5:0]  exp_tap;
  reg  [15:0] exp_cnt;
  reg  [2:0]  sw_cmd;
  wire [31:0] prdata;
  wire [5:0]  tap_position;
  wire        pready, pslverr, delayed_out, step_enable, step_direction, tap_reset;
  integer     seed, bad_count, comparisons, cyc, i;
  // ****************
  // reference model
  // ****************
  // a software reset beats a pin step; a pin step beats a software step
  wire apb_done = psel & penable & pready;
  wire sw_rst   = sw_v & sw_cmd[2];
  wire stepped  = ~tap_reset & ~sw_rst & (step_enable | (sw_v & sw_cmd[0]));
  wire up       = step_enable ? step_direction : sw_cmd[1];
  function [5:0] tap_after(input [5:0] t, input inc);
    begin
      if (inc)
        tap_after = (t == 6'h3F) ? 6'h00 : t + 6'h01;
      else
        tap_after = (t == 6'h00) ? 6'h3F : t - 6'h01;
    end
  endfunction
  // variable mode: the calibration controller is taken to sit beside the line
  tdl_delay_line #(.DELAY_MODE_SELECT(`TDL_MODE_VARIABLE), .INITIAL_TAP_VALUE(INIT)) u_tdl_delay_line (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .delayed_out(delayed_out), .step_enable(step_enable), .step_direction(step_direction),
    .tap_reset(tap_reset), .tap_position(tap_position));
  tdl_step_driver u_tdl_step_driver (.pclk(pclk), .presetn(presetn), .active(active), .slow(slow),
    .hold_en(hold_en), .hold_dir(hold_dir), .hold_rst(hold_rst), .step_enable(step_enable),
    .step_direction(step_direction), .tap_reset(tap_reset));
  // zero-hold and fixed copies see the same pins and bus; their tap must never move
  localparam [5:0] STATIC_INIT = 6'h2A;
  genvar m;
  generate
    for (m = 0; m < 2; m = m + 1) begin : g_static
      localparam [1:0] MODE = (m == 0) ? `TDL_MODE_ZERO_HOLD : `TDL_MODE_FIXED;
      wire [5:0] s_tap;
      tdl_delay_line #(.DELAY_MODE_SELECT(MODE), .INITIAL_TAP_VALUE(STATIC_INIT)) u_tdl_delay_line (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .pad_in(pad_in),
        .delayed_out(), .step_enable(step_enable), .step_direction(step_direction),
        .tap_reset(tap_reset), .tap_position(s_tap));
      always @(negedge pclk) begin
        if (presetn)
          check("stat", 32'(s_tap), 32'(STATIC_INIT));
      end
    end
  endgenerate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_tap <= INIT;
      exp_cnt <= 16'h0000;
      sw_v    <= 1'b0;
    end else begin
      sw_v   <= apb_done & pwrite & (paddr == `TDL_ADDR_CMD);
      sw_cmd <= pwdata[2:0];
      if (tap_reset | sw_rst)
        exp_tap <= INIT;
      else if (stepped)
        exp_tap <= tap_after(exp_tap, up);
      if (apb_done & pwrite & (paddr == `TDL_ADDR_STEPCNT))
        exp_cnt <= {15'h0000, stepped};
      else if (stepped & (exp_cnt != 16'hFFFF))
        exp_cnt <= exp_cnt + 16'h0001;
    end
  end
  always @(negedge pclk) begin
    if (presetn) begin
      check("tap", 32'(tap_position), 32'(exp_tap));
      check("out", 32'(delayed_out), 32'(pad_in));
    end
  end
  always @(posedge pclk) begin
    pad_in <= ^$random(seed);
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ****************
  // tasks
  // ****************
  task check(input [31:0] name, input [31:0] seen, input [31:0] want);
    begin
      comparisons = comparisons + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("wrong value %0s expected %h seen %h", name, want, seen);
      end
    end
  endtask
  // waits on pready with no assumed latency; the bench timeout ends a hang
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd       = prdata;
      err      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task reg_chk(input w, input [11:0] a, input [31:0] want, input e);
    begin
      apb(w, a, 32'hFFFF_FFFF);
      check("data", rd, want);
      check("err", 32'(err), 32'(e));
    end
  endtask
  task pins(input r, input e, input d, input integer n);
    begin
      @(posedge pclk);
      hold_rst <= r;
      hold_en  <= e;
      hold_dir <= d;
      repeat (n) @(posedge pclk);
      hold_rst <= 1'b0;
      hold_en  <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    {seed, bad_count, comparisons, cyc} = {32'h18EB, 32'h0, 32'h0, 32'h0};
    {presetn, psel, penable, pwrite, pad_in, active, slow, hold_en, hold_dir, hold_rst} = 10'h000;
    paddr  = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reg_chk(1'b0, `TDL_ADDR_INIT, {26'h0, INIT}, 1'b0);
    reg_chk(1'b0, `TDL_ADDR_STATUS, {14'h0, 2'b11, 6'h00, `TDL_MODE_VARIABLE, 2'h0, INIT}, 1'b0);
    reg_chk(1'b0, `TDL_ADDR_CMD, 32'h0, 1'b0);
    reg_chk(1'b1, `TDL_ADDR_INIT, 32'h0, 1'b1);
    reg_chk(1'b0, 12'h010, 32'h0, 1'b1);
    $display("test registers done");
    pins(1'b1, 1'b0, 1'b0, 1);
    pins(1'b0, 1'b1, 1'b0, 6);
    check("wrap", 32'(tap_position), 32'h3F);
    pins(1'b0, 1'b1, 1'b1, 1);
    check("wrap", 32'(tap_position), 32'h00);
    pins(1'b1, 1'b1, 1'b1, 2);
    check("rst", 32'(tap_position), 32'(INIT));
    apb(1'b1, `TDL_ADDR_CMD, 32'h3);
    apb(1'b1, `TDL_ADDR_CMD, 32'h5);
    $display("test wrap done");
    active <= 1'b1;
    for (i = 0; i < 40; i = i + 1) begin
      slow <= i[2];
      apb(1'b1, `TDL_ADDR_CMD, $random(seed));
    end
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (100) @(posedge pclk);
    active <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, `TDL_ADDR_STEPCNT, 32'h0);
    check("cnt", rd, 32'(exp_cnt));
    apb(1'b1, `TDL_ADDR_STEPCNT, 32'h0);
    apb(1'b0, `TDL_ADDR_STEPCNT, 32'h0);
    check("cnt", rd, 32'h0);
    $display("test random done");
    wrap_up;
  end
endmodule // testbench
